// ===== design/bhp_pkg.sv
// constants and types for the burst-read, async-write host port
package bhp_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    // configuration word layout
    localparam int CFG_BURST_EN_BIT = 15;
    localparam int CFG_LAT_LSB = 12;
    localparam int CFG_LAT_W = 3;
    localparam int CFG_BL_LSB = 0;
    localparam int CFG_BL_W = 3;
    localparam logic [2:0] LAT_RESET = 3'h7;
    localparam logic [2:0] BL_RESET = 3'h0;
    localparam logic [2:0] BL_LAST_FIXED = 3'h3;
    localparam logic [5:0] BL_BASE_WORDS = 6'h04;
    localparam logic [5:0] WORDS_ONE = 6'h01;
    localparam logic [15:0] ADDR_STEP = 16'h0001;

    typedef enum logic [2:0] {
        BHP_IDLE = 3'b001,
        BHP_WAIT = 3'b010,
        BHP_BURST = 3'b100
    } bhp_state_e;

    typedef struct packed {
        logic host_clk;
        logic address_valid_strobe_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
    } bhp_pins_s;

    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bhp_mem_wr_s;
endpackage

// ===== design/bhp_pin_sync.sv
// two-stage synchroniser for all host pins
`timescale 1ns/1ps
module bhp_pin_sync
    import bhp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // raw and synchronised pins
    input wire bhp_pkg::bhp_pins_s pins,
    output bhp_pkg::bhp_pins_s pins_sync
);
    typedef struct packed {
        bhp_pins_s s1;
        bhp_pins_s s2;
    } bhp_sync_s;

    bhp_sync_s r;
    bhp_sync_s next_r;

    // stage one feeds only stage two
    always_comb
    begin
        next_r.s1 = pins;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            r <= '{s1: '{host_clk: 1'b0, address_valid_strobe_n: 1'b1, ce_n: 1'b1,
                oe_n: 1'b1, we_n: 1'b1, addr: '0, dq: '0},
                s2: '{host_clk: 1'b0, address_valid_strobe_n: 1'b1, ce_n: 1'b1,
                oe_n: 1'b1, we_n: 1'b1, addr: '0, dq: '0}};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign pins_sync = r.s2;
endmodule // bhp_pin_sync

// ===== design/bhp_host_port.sv
// host port: clocked burst reads, asynchronous address-latched writes
`timescale 1ns/1ps
module bhp_host_port
    import bhp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // host pins
    input wire logic host_clk,
    input wire logic address_valid_strobe_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [bhp_pkg::ADDR_W-1:0] addr,
    input wire logic [bhp_pkg::DATA_W-1:0] dq_in,
    output logic [bhp_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    // configuration and status
    input wire logic cfg_write,
    input wire logic [bhp_pkg::DATA_W-1:0] cfg_data,
    input wire logic latched_write_mode,
    output logic burst_enabled,
    output logic [bhp_pkg::CFG_LAT_W-1:0] read_latency,
    output logic [bhp_pkg::CFG_BL_W-1:0] burst_length_field,
    output logic burst_active,
    // buffer side
    output logic [bhp_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [bhp_pkg::DATA_W-1:0] mem_rdata,
    output bhp_pkg::bhp_mem_wr_s mem_write
);
    import bhp_pkg::*;

    typedef struct packed {
        bhp_state_e state;
        logic [CFG_LAT_W-1:0] wait_cnt;
        logic [5:0] words_left;
        logic continuous;
        logic presenting;
        logic [ADDR_W-1:0] burst_addr;
        logic burst_en;
        logic [CFG_LAT_W-1:0] latency;
        logic [CFG_BL_W-1:0] bl;
        logic hclk_prev;
        logic avd_prev;
        logic ce_prev;
        logic we_prev;
        logic [DATA_W-1:0] dq;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] wr_data;
        logic wr_pend;
        bhp_mem_wr_s wr;
    } bhp_regs_s;

    bhp_pins_s p;
    bhp_regs_s r;
    bhp_regs_s next_r;
    logic hclk_rise;
    logic avd_rise;
    logic ce_rise;
    logic we_rise;
    logic start;

    bhp_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pins({host_clk, address_valid_strobe_n,
            ce_n, oe_n, we_n, addr, dq_in}),
        .pins_sync(p)
    );

    assign hclk_rise = p.host_clk & ~r.hclk_prev;
    assign avd_rise = p.address_valid_strobe_n & ~r.avd_prev;
    assign ce_rise = p.ce_n & ~r.ce_prev;
    assign we_rise = p.we_n & ~r.we_prev;
    // burst start: host edge with strobe low, selected, not writing
    assign start = r.burst_en & hclk_rise & ~p.address_valid_strobe_n & ~p.ce_n & p.we_n;

    always_comb
    begin
        next_r = r;
        next_r.hclk_prev = p.host_clk;
        next_r.avd_prev = p.address_valid_strobe_n;
        next_r.ce_prev = p.ce_n;
        next_r.we_prev = p.we_n;
        next_r.wr.wr = 1'b0;
        // configuration word
        if (cfg_write)
        begin
            next_r.burst_en = cfg_data[CFG_BURST_EN_BIT];
            next_r.latency = cfg_data[CFG_LAT_LSB +: CFG_LAT_W];
            next_r.bl = cfg_data[CFG_BL_LSB +: CFG_BL_W];
        end
        // asynchronous read path while burst mode is off
        if (!r.burst_en)
        begin
            next_r.dq = mem_rdata;
        end
        unique case (r.state)
            BHP_IDLE:
            begin
                next_r.presenting = 1'b0;
            end
            BHP_WAIT:
            begin
                // wait states, first word a cycle or more later
                if (hclk_rise)
                begin
                    if (r.wait_cnt == '0)
                    begin
                        next_r.dq = mem_rdata;
                        next_r.presenting = 1'b1;
                        next_r.burst_addr = r.burst_addr + ADDR_STEP;
                        next_r.state = BHP_BURST;
                    end
                    else
                    begin
                        next_r.wait_cnt = r.wait_cnt - 3'h1;
                    end
                end
            end
            BHP_BURST:
            begin
                // one word per host edge, linear address
                if (hclk_rise)
                begin
                    if (r.words_left == '0 && !r.continuous)
                    begin
                        next_r.presenting = 1'b0;
                        next_r.state = BHP_IDLE;
                    end
                    else
                    begin
                        next_r.dq = mem_rdata;
                        next_r.burst_addr = r.burst_addr + ADDR_STEP;
                        next_r.words_left = r.words_left - WORDS_ONE;
                    end
                end
            end
        endcase
        // start or restart a burst, word count from length field
        if (start)
        begin
            next_r.state = BHP_WAIT;
            next_r.wait_cnt = r.latency;
            next_r.burst_addr = p.addr;
            next_r.presenting = 1'b0;
            next_r.continuous = (r.bl > BL_LAST_FIXED);
            next_r.words_left = (BL_BASE_WORDS << r.bl[1:0]) - WORDS_ONE;
        end
        // deselect, burst mode off or a write ends any burst
        if (p.ce_n || !r.burst_en || !p.we_n)
        begin
            next_r.state = BHP_IDLE;
            next_r.presenting = 1'b0;
        end
        // writes never look at the host clock
        if (we_rise && !p.ce_n)
        begin
            next_r.wr_data = p.dq;
            next_r.wr_pend = 1'b1;
        end
        if (latched_write_mode)
        begin
            // address on strobe rise, issued at write strobe rise
            if (avd_rise)
            begin
                next_r.wr_addr = p.addr;
            end
            if (we_rise && !p.ce_n)
            begin
                next_r.wr = '{wr: 1'b1, addr: r.wr_addr, data: p.dq};
                next_r.wr_pend = 1'b0;
            end
        end
        else if (ce_rise && (r.wr_pend || we_rise))
        begin
            // address on chip select rise
            next_r.wr = '{wr: 1'b1, addr: p.addr, data: we_rise ? p.dq : r.wr_data};
            next_r.wr_pend = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            // burst off, latency seven after reset
            r <= '{state: BHP_IDLE, wait_cnt: '0, words_left: '0, continuous: 1'b0,
                presenting: 1'b0, burst_addr: '0, burst_en: 1'b0, latency: LAT_RESET,
                bl: BL_RESET, hclk_prev: 1'b0, avd_prev: 1'b1, ce_prev: 1'b1,
                we_prev: 1'b1, dq: '0, wr_addr: '0, wr_data: '0, wr_pend: 1'b0,
                wr: '{wr: 1'b0, addr: '0, data: '0}};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign mem_addr = r.burst_en ? r.burst_addr : p.addr;
    assign dq_out = r.dq;
    // drive only while selected, output enabled, reading
    assign dq_oe = ~p.ce_n & ~p.oe_n & p.we_n & (~r.burst_en | r.presenting);
    assign burst_enabled = r.burst_en;
    assign read_latency = r.latency;
    assign burst_length_field = r.bl;
    assign burst_active = (r.state != BHP_IDLE);
    assign mem_write = r.wr;

    // helper: host edges since burst start, latency at start
    logic [3:0] edge_cnt;
    logic [2:0] lat_start;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            edge_cnt <= 4'h0;
            lat_start <= 3'h0;
        end
        else if (start)
        begin
            edge_cnt <= 4'h0;
            lat_start <= r.latency;
        end
        else if (hclk_rise && edge_cnt != 4'hF)
        begin
            edge_cnt <= edge_cnt + 4'h1;
        end
    end

    a_latency_reset: assert property (@(posedge ref_clk)
        $fell(rst) |-> read_latency == LAT_RESET)
        else $error("latency not seven after reset");
    a_async_default: assert property (@(posedge ref_clk) disable iff (rst)
        !burst_enabled |-> !burst_active && !r.presenting)
        else $error("burst activity while burst mode off");
    a_cfg_burst_bit: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_write |=> burst_enabled == $past(cfg_data[CFG_BURST_EN_BIT])
        && read_latency == $past(cfg_data[CFG_LAT_LSB +: CFG_LAT_W]))
        else $error("config word not applied");
    a_first_word_wait: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(r.presenting) |-> edge_cnt == {1'b0, lat_start} + 4'h1)
        else $error("first word not after programmed latency");
    a_no_early_word: assert property (@(posedge ref_clk) disable iff (rst)
        start |=> !r.presenting && burst_active)
        else $error("word presented with strobe edge");
    a_start_addr: assert property (@(posedge ref_clk) disable iff (rst)
        start |=> mem_addr == $past(p.addr))
        else $error("start address not captured");
    a_linear_step: assert property (@(posedge ref_clk) disable iff (rst)
        r.state == BHP_BURST && hclk_rise && !start && !p.ce_n && p.we_n
        && (r.words_left != 6'h00 || r.continuous) |=> mem_addr == $past(mem_addr) + 16'h0001)
        else $error("burst address did not step by one");
    a_burst_end: assert property (@(posedge ref_clk) disable iff (rst)
        r.state == BHP_BURST && hclk_rise && !start && r.words_left == 6'h00 && !r.continuous
        |=> !burst_active)
        else $error("burst ran past its length");
    a_deselect_float: assert property (@(posedge ref_clk) disable iff (rst)
        p.ce_n |-> !dq_oe ##1 !burst_active)
        else $error("drive or burst while deselected");
    a_no_write_burst: assert property (@(posedge ref_clk) disable iff (rst)
        !p.we_n |=> !burst_active)
        else $error("burst during write");
    a_ce_latch_addr: assert property (@(posedge ref_clk) disable iff (rst)
        !latched_write_mode && ce_rise && r.wr_pend
        |=> mem_write.wr && mem_write.addr == $past(p.addr))
        else $error("write address not taken at select rise");
    a_avd_latch_addr: assert property (@(posedge ref_clk) disable iff (rst)
        latched_write_mode && we_rise && !p.ce_n
        |=> mem_write.wr && mem_write.addr == $past(r.wr_addr))
        else $error("write address not from strobe rise");
    a_write_pulse: assert property (@(posedge ref_clk) disable iff (rst)
        mem_write.wr |=> !mem_write.wr)
        else $error("write issued for more than one cycle");
endmodule // bhp_host_port

// ===== sim/bhp_host_model.sv
// host bus controller model driving the port's pins
`timescale 1ns/1ps
module bhp_host_model
(
    // clock
    input wire logic ref_clk,
    // pins and sampled words
    output bhp_pkg::bhp_pins_s pins,
    output logic dq_en,
    input wire logic [bhp_pkg::DATA_W-1:0] dq_seen,
    output logic rd_valid,
    output logic [bhp_pkg::DATA_W-1:0] rd_word
);
    import bhp_pkg::*;
    initial
    begin
        pins = {5'h0F, 32'h0};
        dq_en = 1'b0;
        rd_valid = 1'b0;
        rd_word = 16'h0000;
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // one host clock period, 3 ref_clk high and 3 low
    task automatic rise(input logic smp);
        pins.host_clk <= 1'b1;
        #1 rd_word = dq_seen;
        rd_valid = smp;
        step(1);
        #1 rd_valid = 1'b0;
        step(2);
        pins.host_clk <= 1'b0;
        step(3);
    endtask
    task automatic burst(input logic [15:0] a, input int lat, input int n);
        pins.ce_n <= 1'b0;
        pins.oe_n <= 1'b0;
        pins.address_valid_strobe_n <= 1'b0;
        pins.addr <= a;
        step(3);
        rise(1'b0);
        pins.address_valid_strobe_n <= 1'b1;
        pins.addr <= ~a;
        for (int r = 1; r <= lat + 1 + n; r++)
            rise(r >= lat + 2);
    endtask
    task automatic idle();
        pins <= {5'h0F, ~pins.addr, pins.dq};
        step(1);
    endtask
    task automatic write(input logic [15:0] a, input logic [15:0] d, input logic lt);
        pins.ce_n <= 1'b0;
        pins.address_valid_strobe_n <= 1'b0;
        pins.addr <= a; // word addressing, bit 0 a plain address bit
        step(3);
        if (lt)
        begin
            pins.address_valid_strobe_n <= 1'b1;
            step(1);
            pins.addr <= ~a;
        end
        pins.we_n <= 1'b0;
        pins.dq <= d;
        dq_en <= 1'b1;
        pins.host_clk <= 1'b1;
        step(3);
        pins.host_clk <= 1'b0;
        step(3);
        pins.we_n <= 1'b1;
        step(3);
        pins.ce_n <= 1'b1;
        pins.address_valid_strobe_n <= 1'b1;
        step(3);
        dq_en <= 1'b0;
        pins.addr <= ~pins.addr;
        step(1);
    endtask
endmodule // bhp_host_model

// ===== sim/test_bhp_host_port.sv
// self-checking bench for the host port
`timescale 1ns/1ps
module test_bhp_host_port;
    import bhp_pkg::*;
    logic ref_clk, rst, cfg_write, latched_write_mode, hen, rd_valid, dq_oe;
    logic burst_enabled, burst_active;
    logic [15:0] cfg_data, dq_out, dq_in, mem_addr, mem_rdata, rd_word;
    logic [15:0] pat = 16'hA5A5;
    logic [2:0] read_latency, burst_length_field;
    bhp_pins_s pins;
    bhp_mem_wr_s mem_write;
    int fail_count = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h921FC8CD;
    logic [15:0] rd_q[$];
    logic [31:0] wr_q[$];
    assign mem_rdata = mem_addr ^ 16'h5A3C;
    assign dq_in = dq_oe ? dq_out : (hen ? pins.dq : pat);
    always @(posedge ref_clk) pat <= ~pat;
    bhp_host_port dut (.ref_clk(ref_clk), .rst(rst), .host_clk(pins.host_clk),
        .address_valid_strobe_n(pins.address_valid_strobe_n), .ce_n(pins.ce_n),
        .oe_n(pins.oe_n), .we_n(pins.we_n), .addr(pins.addr), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .cfg_write(cfg_write), .cfg_data(cfg_data),
        .latched_write_mode(latched_write_mode), .burst_enabled(burst_enabled),
        .read_latency(read_latency), .burst_length_field(burst_length_field),
        .burst_active(burst_active), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_write(mem_write));
    bhp_host_model host (.ref_clk(ref_clk), .pins(pins), .dq_en(hen), .dq_seen(dq_in),
        .rd_valid(rd_valid), .rd_word(rd_word));
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cfg(input logic en, input logic [2:0] lat, input logic [2:0] bl);
        cfg_write <= 1'b1;
        cfg_data <= {en, lat, 9'h000, bl};
        @(posedge ref_clk);
        cfg_write <= 1'b0;
        @(posedge ref_clk);
        check({burst_enabled, read_latency, burst_length_field}, {en, lat, bl});
    endtask
    // results are taken off the queues as they appear
    always @(posedge ref_clk)
    begin
        if (rd_valid)
            check(rd_word, rd_q.pop_front());
        if (mem_write.wr)
            check({mem_write.addr, mem_write.data}, wr_q.pop_front());
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        finish_test();
    end
    initial
    begin
        logic [15:0] a, d;
        int n;
        rst = 1'b1;
        cfg_write = 1'b0;
        cfg_data = 16'h0000;
        latched_write_mode = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({burst_enabled, read_latency, burst_length_field, burst_active}, 8'h70);
        a = 16'(rnd());
        host.burst(a, 0, 0);
        repeat (3) @(posedge ref_clk);
        check({burst_active, dq_out}, {1'b0, ~a ^ 16'h5A3C});
        host.idle();
        for (int i = 0; i < 8; i++)
        begin
            a = 16'(rnd());
            n = (i % 5 == 4) ? 6 : 4 << (i % 5);
            cfg(1'b1, 3'(i), (i % 5 == 4) ? 3'(4 + rnd() % 4) : 3'(i % 5));
            for (int j = 0; j < n; j++)
                rd_q.push_back((a + 16'(j)) ^ 16'h5A3C);
            host.burst(a, i, n);
            repeat (5) @(posedge ref_clk);
            check(burst_active, i % 5 == 4);
            host.idle();
            repeat (4) @(posedge ref_clk);
            check(dq_oe, 1'b0);
        end
        for (int k = 0; k < 4; k++)
        begin
            a = 16'(rnd());
            d = 16'(rnd());
            latched_write_mode <= k[0];
            wr_q.push_back({a, d});
            host.write(a, d, k[0]);
            check(burst_active, 1'b0);
        end
        repeat (4) @(posedge ref_clk);
        check(wr_q.size(), 0);
        check(rd_q.size(), 0);
        cfg(1'b1, 3'h2, 3'h1);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({burst_enabled, read_latency}, 4'h7);
        finish_test();
    end
endmodule // test_bhp_host_port
